/* rtl/ats_map.svh */
// address tenure start block: constants
`ifndef ATS_MAP_SVH
`define ATS_MAP_SVH

`define ATS_ADDR_W       32
`define ATS_TT_W         5
`define ATS_EXTENDED_TRANSFER_CODE_W       8
// tt bit 1 high marks a data-carrying memory operation
`define ATS_TT_DATA_BIT  1
// burst alignment: double word clears low 3 bits
`define ATS_ALIGN_MASK   32'hFFFF_FFF8
`define ATS_NEG          1'b1
`define ATS_ASSERT_LVL   1'b0

`endif

/* rtl/ats_pkg.sv */
// address tenure start block: types
package ats_pkg;
  typedef enum logic [2:0] {
    ATS_IDLE,
    ATS_MEM_START,
    ATS_MEM_HOLD,
    ATS_DS_BEAT0,
    ATS_DS_BEAT1,
    ATS_RELEASE
  } ats_state_t;
endpackage

/* rtl/ats_tenure.sv */
// address tenure master and snoop start logic
`timescale 1ns/1ps
`include "ats_map.svh"
// Behaviour
// - qualified grant needs grant, no tenure, retry negated now and before.
// - memory start strobe only while address and attributes are valid.
// - data-type memory start implies data bus request; address-only does not.
// - memory start stays negated during our direct-store tenure.
// - direct-store start stays negated during our memory tenure.
// - start strobe asserts with busy and lasts exactly one clock.
// - strobe goes high impedance one clock after its negation.
// - sampled memory start makes address and attributes valid for snooping.
// - sampled direct-store start triggers reply check; negated means none.
// - direct-store start with first beat; data request unless req_ds_addr_only is set.
// - burst address is double-word aligned at critical or first word.
// - burst address held constant for whole burst.
// - memory address driven cycle after qualified grant with busy, start.
// - memory address released one clock after address acknowledge.
// - snooped address sampled only in the incoming start cycle.
// - direct-store tenure has control/tag packet then address packet.
// - first direct-store beat after grant, second beat next clock.
module ats_tenure (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // user request side
  input  wire logic                      req_valid,
  input  wire logic                      req_is_ds,
  input  wire logic                      req_burst,
  input  wire logic [`ATS_ADDR_W-1:0]    req_addr,
  input  wire logic [`ATS_ADDR_W-1:0]    req_ds_packet0,
  input  wire logic [`ATS_TT_W-1:0]      req_tt,
  input  wire logic [`ATS_EXTENDED_TRANSFER_CODE_W-1:0]    req_extended_transfer_code,
  input  wire logic                      req_ds_addr_only,
  output logic                           req_taken,
  output logic                           tenure_done,
  output logic                           data_bus_req,
  // bus arbitration
  input  wire logic                      grant_input_b,
  input  wire logic                      address_retry_b,
  input  wire logic                      address_acknowledge_b,
  // start strobes (active low, tri-state)
  input  wire logic                      memory_start_strobe_b_i,
  output logic                           memory_start_strobe_b_o,
  output logic                           memory_start_strobe_oe,
  input  wire logic                      direct_store_start_strobe_b_i,
  output logic                           direct_store_start_strobe_b_o,
  output logic                           direct_store_start_strobe_oe,
  input  wire logic                      address_bus_busy_b_i,
  output logic                           address_bus_busy_b_o,
  output logic                           address_bus_busy_oe,
  // address and type lines
  input  wire logic [`ATS_ADDR_W-1:0]    addr_i,
  output logic [`ATS_ADDR_W-1:0]         addr_o,
  output logic                           addr_oe,
  input  wire logic [`ATS_TT_W-1:0]      transfer_type_code_i,
  output logic [`ATS_TT_W-1:0]           transfer_type_code_o,
  output logic                           transfer_type_code_oe,
  // snoop side
  output logic                           snoop_valid,
  output logic [`ATS_ADDR_W-1:0]         snoop_addr,
  output logic [`ATS_TT_W-1:0]           snoop_tt,
  output logic                           ds_reply_check,
  output logic [`ATS_ADDR_W-1:0]         ds_reply_packet
);

  ////////////////////////////////////////////////////////////////////////////
  ats_pkg::ats_state_t state_q;
  ats_pkg::ats_state_t state_d;
  logic                   retry_prev_q;
  logic                   ext_tenure_q;
  logic                   ds_q;
  logic [`ATS_ADDR_W-1:0] ds_addr_q;

  // busy seen from others or our own tenure counts as in progress
  wire ext_start   = (memory_start_strobe_b_i == `ATS_ASSERT_LVL) ||
                     (direct_store_start_strobe_b_i == `ATS_ASSERT_LVL);
  wire ack         = (address_acknowledge_b == `ATS_ASSERT_LVL);
  wire ext_busy    = (address_bus_busy_b_i == `ATS_ASSERT_LVL);
  wire own_tenure  = (state_q != ats_pkg::ATS_IDLE);
  wire in_tenure   = own_tenure || ext_tenure_q || ext_busy || ext_start;
  wire retry_now   = (address_retry_b == `ATS_ASSERT_LVL);
  wire qual_grant  = (grant_input_b == `ATS_ASSERT_LVL) && !in_tenure &&
                     !retry_now && !retry_prev_q;
  wire take        = qual_grant && req_valid;
  wire tt_data     = req_tt[`ATS_TT_DATA_BIT];
  wire [`ATS_ADDR_W-1:0] mem_addr =
    req_burst ? (req_addr & `ATS_ALIGN_MASK) : req_addr;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ats_pkg::ATS_IDLE:
        if (take)
          state_d = req_is_ds ? ats_pkg::ATS_DS_BEAT0
                              : ats_pkg::ATS_MEM_START;
      ats_pkg::ATS_MEM_START:
        state_d = ack ? ats_pkg::ATS_RELEASE : ats_pkg::ATS_MEM_HOLD;
      ats_pkg::ATS_MEM_HOLD:
        if (ack)
          state_d = ats_pkg::ATS_RELEASE;
      ats_pkg::ATS_DS_BEAT0:
        state_d = ats_pkg::ATS_DS_BEAT1;
      ats_pkg::ATS_DS_BEAT1:
        if (ack)
          state_d = ats_pkg::ATS_RELEASE;
      default:
        state_d = ats_pkg::ATS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q      <= ats_pkg::ATS_IDLE;
      retry_prev_q <= 1'b0;
      ext_tenure_q <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      retry_prev_q <= retry_now;
      // foreign window: start through the acknowledge cycle
      if (ext_start && !own_tenure)
        ext_tenure_q <= 1'b1;
      else if (ack)
        ext_tenure_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master outputs; memory address held unchanged until release, direct-store address changes at second beat
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      memory_start_strobe_b_o       <= `ATS_NEG;
      memory_start_strobe_oe        <= 1'b0;
      direct_store_start_strobe_b_o <= `ATS_NEG;
      direct_store_start_strobe_oe  <= 1'b0;
      address_bus_busy_b_o          <= `ATS_NEG;
      address_bus_busy_oe           <= 1'b0;
      addr_o                        <= '0;
      addr_oe                       <= 1'b0;
      transfer_type_code_o          <= '0;
      transfer_type_code_oe         <= 1'b0;
      data_bus_req                  <= 1'b0;
      req_taken                     <= 1'b0;
      tenure_done                   <= 1'b0;
      ds_q                          <= 1'b0;
      ds_addr_q                     <= '0;
    end
    else
    begin
      req_taken    <= take && (state_q == ats_pkg::ATS_IDLE);
      tenure_done  <= (state_q == ats_pkg::ATS_RELEASE);
      data_bus_req <= 1'b0;
      // strobes: one-cycle low pulse, then driven high one cycle, then off
      memory_start_strobe_b_o       <= `ATS_NEG;
      direct_store_start_strobe_b_o <= `ATS_NEG;
      memory_start_strobe_oe        <= 1'b0;
      direct_store_start_strobe_oe  <= 1'b0;
      if (state_q == ats_pkg::ATS_IDLE && take)
      begin
        ds_q                  <= req_is_ds;
        ds_addr_q             <= req_addr;
        address_bus_busy_b_o  <= `ATS_ASSERT_LVL;
        address_bus_busy_oe   <= 1'b1;
        addr_oe               <= 1'b1;
        transfer_type_code_oe <= 1'b1;
        if (req_is_ds)
        begin
          direct_store_start_strobe_b_o <= `ATS_ASSERT_LVL;
          direct_store_start_strobe_oe  <= 1'b1;
          memory_start_strobe_oe        <= 1'b0;
          addr_o                        <= req_ds_packet0;
          transfer_type_code_o          <= req_extended_transfer_code[7:3];
          data_bus_req                  <= !req_ds_addr_only;
        end
        else
        begin
          memory_start_strobe_b_o <= `ATS_ASSERT_LVL;
          memory_start_strobe_oe  <= 1'b1;
          addr_o                  <= mem_addr;
          transfer_type_code_o    <= req_tt;
          data_bus_req            <= tt_data;
        end
      end
      else if (state_q == ats_pkg::ATS_MEM_START)
        memory_start_strobe_oe <= 1'b1;
      else if (state_q == ats_pkg::ATS_DS_BEAT0)
      begin
        direct_store_start_strobe_oe <= 1'b1;
        addr_o                       <= ds_addr_q;
      end
      // release one clock after acknowledge
      if (state_q == ats_pkg::ATS_RELEASE)
      begin
        address_bus_busy_b_o  <= `ATS_NEG;
        addr_oe               <= 1'b0;
        transfer_type_code_oe <= 1'b0;
      end
      if (state_q == ats_pkg::ATS_IDLE && !take)
        address_bus_busy_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // snoop: address sampled only in start cycle; strobes trusted to last
  // one clock as other masters promise
  wire snoop_mem = (memory_start_strobe_b_i == `ATS_ASSERT_LVL) && !own_tenure;
  wire snoop_ds  = (direct_store_start_strobe_b_i == `ATS_ASSERT_LVL) &&
                   !own_tenure;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      snoop_valid     <= 1'b0;
      snoop_addr      <= '0;
      snoop_tt        <= '0;
      ds_reply_check  <= 1'b0;
      ds_reply_packet <= '0;
    end
    else
    begin
      snoop_valid    <= snoop_mem;
      ds_reply_check <= snoop_ds;
      if (snoop_mem)
      begin
        snoop_addr <= addr_i;
        snoop_tt   <= transfer_type_code_i;
      end
      if (snoop_ds)
        ds_reply_packet <= addr_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_qual_grant_rule: assert property (@(posedge clk) disable iff (!rst_b)
    req_taken |-> $past(!retry_now) && $past(!retry_prev_q))
    else $error("tenure taken without a qualified grant");
  a_start_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(memory_start_strobe_b_o) |=> memory_start_strobe_b_o &&
      memory_start_strobe_oe ##1 !memory_start_strobe_oe)
    else $error("memory start not a one-cycle pulse then release");
  a_ds_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(direct_store_start_strobe_b_o) |=> direct_store_start_strobe_b_o
      ##1 !direct_store_start_strobe_oe)
    else $error("direct-store start not pulse then release");
  a_start_with_busy: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(memory_start_strobe_b_o) |-> $fell(address_bus_busy_b_o) &&
      addr_oe)
    else $error("memory start without busy and address");
  a_no_ts_in_ds: assert property (@(posedge clk) disable iff (!rst_b)
    (ds_q && own_tenure) |-> memory_start_strobe_b_o)
    else $error("memory start during direct-store tenure");
  a_no_direct_store_start_strobe_in_mem: assert property (@(posedge clk) disable iff (!rst_b)
    (!ds_q && own_tenure) |-> direct_store_start_strobe_b_o)
    else $error("direct-store start during memory tenure");
  a_addr_held: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ats_pkg::ATS_MEM_HOLD) |-> $stable(addr_o))
    else $error("burst address changed during tenure");
  a_addr_release: assert property (@(posedge clk) disable iff (!rst_b)
    (ack && own_tenure && state_q != ats_pkg::ATS_DS_BEAT0)
      |=> ##1 !addr_oe)
    else $error("address not released after acknowledge");
  a_ds_second_beat: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(direct_store_start_strobe_b_o) |=> addr_o == ds_addr_q)
    else $error("second direct-store beat missing");
  a_snoop_sample: assert property (@(posedge clk) disable iff (!rst_b)
    snoop_mem |=> snoop_valid && snoop_addr == $past(addr_i))
    else $error("snoop address not taken in start cycle");
  c_mem_tenure: cover property (@(posedge clk) disable iff (!rst_b)
    $fell(memory_start_strobe_b_o) ##[1:20] tenure_done);
  c_ds_tenure: cover property (@(posedge clk) disable iff (!rst_b)
    $fell(direct_store_start_strobe_b_o) ##[2:20] tenure_done);
  c_snoop_mem: cover property (@(posedge clk) disable iff (!rst_b)
    snoop_valid);
  c_ds_reply: cover property (@(posedge clk) disable iff (!rst_b)
    ds_reply_check);

endmodule // ats_tenure

/* dv/ats_bus_model.sv */
// far side of the tenure block: parked arbiter, acknowledger, other master
`timescale 1ns/1ps
`include "ats_map.svh"
module ats_bus_model (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic [3:0]             ack_delay,
  input  wire logic [1:0]             snoop_go,
  input  wire logic [`ATS_ADDR_W-1:0] snoop_a,
  input  wire logic                   ts_w_b,
  input  wire logic                   xs_w_b,
  output logic                        grant_input_b,
  output logic                        address_acknowledge_b,
  output logic                        f_ts_b,
  output logic                        f_xs_b,
  output logic                        f_abb_b,
  output logic [`ATS_ADDR_W-1:0]      f_addr,
  output logic [`ATS_TT_W-1:0]        f_tt
);
  logic [3:0] cnt_q;

  // parked: grant always offered, qualification is the block's job
  assign grant_input_b = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_q                 <= 4'h0;
      address_acknowledge_b <= 1'b1;
      f_ts_b                <= 1'b1;
      f_xs_b                <= 1'b1;
      f_abb_b               <= 1'b1;
      f_addr                <= 32'h0;
      f_tt                  <= 5'h00;
    end
    else
    begin
      // bench only pulses snoop_go with the bus idle
      f_ts_b  <= !snoop_go[0];
      f_xs_b  <= !snoop_go[1];
      // lines valid in the start cycle only, then toggling
      f_addr  <= (|snoop_go) ? snoop_a : ~f_addr;
      f_tt    <= (|snoop_go) ? 5'h0A : ~f_tt;
      if (|snoop_go)
        f_abb_b <= 1'b0;
      else if (!address_acknowledge_b)
        f_abb_b <= 1'b1;
      if (!ts_w_b || !xs_w_b)
      begin
        cnt_q                 <= ack_delay;
        address_acknowledge_b <= (ack_delay != 4'h0);
      end
      else if (cnt_q != 4'h0)
      begin
        cnt_q                 <= cnt_q - 4'h1;
        address_acknowledge_b <= (cnt_q != 4'h1);
      end
      else
        address_acknowledge_b <= 1'b1;
    end
  end
endmodule // ats_bus_model

/* dv/tb_top.sv */
// self-checking testbench for the address tenure start block
`timescale 1ns/1ps
`include "ats_map.svh"
module tb_top;
  logic        clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_is_ds = 1'b0;
  logic        req_burst = 1'b0, ao = 1'b0, address_retry_b = 1'b1;
  logic [31:0] req_addr = 32'h0, pk0 = 32'h0, snoop_a = 32'h0;
  logic [4:0]  req_tt = 5'h00;
  logic [7:0]  req_extended_transfer_code = 8'h00;
  logic [3:0]  ack_delay = 4'h0;
  logic [1:0]  snoop_go = 2'b00;
  logic        gnt_b, ack_b, f_ts_b, f_xs_b, f_abb_b, taken, done, dbr;
  logic        ts_o, ts_oe, xs_o, xs_oe, bb_o, bb_oe, a_oe, t_oe, sv, rc;
  logic        ts_w, xs_w, bb_w;
  logic [31:0] f_addr, a_o, a_w, s_a, r_p;
  logic [4:0]  f_tt, t_o, t_w, s_t;
  int          bad_count = 0, n_checks = 0;

  always #4 clk = ~clk;
  // wired pins: owner drives, else the far side (pull-up on strobes/busy)
  assign ts_w = ts_oe ? ts_o : f_ts_b;
  assign xs_w = xs_oe ? xs_o : f_xs_b;
  assign bb_w = bb_oe ? bb_o : f_abb_b;
  assign a_w  = a_oe ? a_o : f_addr;
  assign t_w  = t_oe ? t_o : f_tt;

  ats_bus_model u_bus (.clk(clk), .rst_b(rst_b), .ack_delay(ack_delay),
    .snoop_go(snoop_go), .snoop_a(snoop_a), .ts_w_b(ts_w), .xs_w_b(xs_w),
    .grant_input_b(gnt_b), .address_acknowledge_b(ack_b), .f_ts_b(f_ts_b),
    .f_xs_b(f_xs_b), .f_abb_b(f_abb_b), .f_addr(f_addr), .f_tt(f_tt));

  ats_tenure u_dut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_is_ds(req_is_ds), .req_burst(req_burst), .req_addr(req_addr),
    .req_ds_packet0(pk0), .req_tt(req_tt), .req_extended_transfer_code(req_extended_transfer_code),
    .req_ds_addr_only(ao), .req_taken(taken), .tenure_done(done),
    .data_bus_req(dbr), .grant_input_b(gnt_b),
    .address_retry_b(address_retry_b), .address_acknowledge_b(ack_b),
    .memory_start_strobe_b_i(ts_w), .memory_start_strobe_b_o(ts_o),
    .memory_start_strobe_oe(ts_oe), .direct_store_start_strobe_b_i(xs_w),
    .direct_store_start_strobe_b_o(xs_o),
    .direct_store_start_strobe_oe(xs_oe), .address_bus_busy_b_i(bb_w),
    .address_bus_busy_b_o(bb_o), .address_bus_busy_oe(bb_oe),
    .addr_i(a_w), .addr_o(a_o), .addr_oe(a_oe), .transfer_type_code_i(t_w),
    .transfer_type_code_o(t_o), .transfer_type_code_oe(t_oe),
    .snoop_valid(sv), .snoop_addr(s_a), .snoop_tt(s_t),
    .ds_reply_check(rc), .ds_reply_packet(r_p));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  // one own tenure; rty cycles of retry first, ad cycles before acknowledge
  task automatic do_op(input logic ds, input logic bst, input logic [31:0] a,
    input logic [4:0] tt, input logic aon, input int rty,
    input logic [3:0] ad, input logic edbr);
    int          i;
    logic [31:0] ea;
    ea = (bst && !ds) ? (a & `ATS_ALIGN_MASK) : a;
    ack_delay = ad;
    req_is_ds = ds;
    req_burst = bst;
    req_addr = a;
    pk0 = ~a;
    req_tt = tt;
    req_extended_transfer_code = {tt, 3'h5};
    ao = aon;
    req_valid = 1'b1;
    address_retry_b = (rty == 0);
    i = 0;
    while (taken !== 1'b1 && i < 50)
    begin
      tick;
      i++;
      if (i == rty)
        address_retry_b = 1'b1;
    end
    if (i >= 50)
    begin
      bad_count++;
      test_done();
    end
    chk("take_wait", (rty == 0) ? 1 : rty + 2, i);
    req_valid = 1'b0;
    chk("start", {bb_w, ts_w, xs_w}, {1'b0, ds, !ds});
    chk("addr_first", ds ? ~a : ea, a_w);
    chk("type_first", tt, t_w);
    chk("data_req", edbr, dbr);
    tick;
    chk("negated", {ts_w, xs_w, ds ? xs_oe : ts_oe}, 3'h7);
    chk("addr_second", ea, a_w);
    while (done !== 1'b1 && i < 60)
    begin
      tick;
      i++;
      if (i == rty + 3)
        chk("strobe_off", 0, ds ? xs_oe : ts_oe);
      if (a_oe === 1'b1 && !ds)
        chk("addr_held", ea, a_w);
    end
    if (i >= 60)
    begin
      bad_count++;
      test_done();
    end
    // negation tick is not counted in i
    chk("done_at", (rty == 0 ? 1 : rty + 2) + 2 + ad, i);
    chk("released", {a_oe, bb_w}, 2'b01);
  endtask

  task automatic snoop(input logic ds, input logic [31:0] a);
    snoop_a = a;
    snoop_go = ds ? 2'b10 : 2'b01;
    ack_delay = 4'h1;
    tick;
    snoop_go = 2'b00;
    tick;
    chk("snoop_flags", {sv, rc}, {!ds, ds});
    chk("snoop_addr", a, ds ? r_p : s_a);
    if (!ds)
      chk("snoop_type", 5'h0A, s_t);
    tick;
    chk("snoop_once", {sv, rc, ds ? r_p : s_a}, {2'b00, a});
    repeat (4) tick;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    chk("reset", {ts_oe, xs_oe, bb_oe, a_oe, t_oe, ts_o, xs_o, bb_o, taken,
        done, dbr, sv, rc}, 13'h00E0);
    rst_b = 1'b1;
    tick;
    do_op(1'b0, 1'b0, 32'h0000_1234, 5'h0A, 1'b0, 0, 4'h0, 1'b1);
    // back to back, burst with a slow acknowledge
    do_op(1'b0, 1'b1, 32'h8000_0F1C, 5'h0E, 1'b0, 0, 4'h3, 1'b1);
    do_op(1'b0, 1'b0, 32'hC000_0040, 5'h04, 1'b0, 0, 4'h1, 1'b0);
    do_op(1'b0, 1'b0, 32'h0000_2000, 5'h0A, 1'b0, 3, 4'h0, 1'b1);
    do_op(1'b1, 1'b0, 32'h4000_0100, 5'h0A, 1'b0, 0, 4'h0, 1'b1);
    do_op(1'b1, 1'b0, 32'h4000_0200, 5'h0A, 1'b1, 0, 4'h2, 1'b0);
    snoop(1'b0, 32'hDEAD_BEE8);
    snoop(1'b1, 32'h1357_9BDF);
    test_done();
  end
endmodule // tb_top
